/* File: pkg/stc_defines.vh */
// Offsets, field positions, reset values and cycle counts of the two-wire timing block
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH

`define STC_NUM_LANES 2
`define STC_ADR_W 8

`define STC_OFS_CTRL 8'h00
`define STC_OFS_STATUS 8'h04
`define STC_OFS_MASK 8'h08
`define STC_OFS_LINES 8'h0C

`define STC_CTRL_RESET 16'h0000
`define STC_LANE_W 8
`define STC_F_SDD 0
`define STC_F_SWAP 2
`define STC_F_TOE 3
`define STC_F_FTE 4
`define STC_F_EXT 5
`define STC_F_EN 6

`define STC_EV_W 6
`define STC_EV_PER_LANE 3
`define STC_EV_START 0
`define STC_EV_FREE 1
`define STC_EV_TMO 2

`define STC_HOLD_NORM 4'h3
`define STC_HOLD_EXT 4'hC
`define STC_SETUP_NORM 4'h1
`define STC_SETUP_EXT 4'hB

`define STC_GAP_BASE 4'h1
`define STC_GAP_ADD1 4'h2
`define STC_GAP_ADD2 4'h4
`define STC_GAP_ADD3 4'h8

`define STC_FREE_PERIODS 4'hA
`define STC_CNT_MAX 4'hF

`endif

/* File: logic/stc_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module stc_sync (
  input wire mclk_i,
  input wire rst_i,
  input wire async_i,
  output wire level_o
);
  reg meta_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;

  // First stage feeds only the second stage
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      meta_reg <= async_i;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_o = level_reg;
endmodule // stc_sync

/* File: logic/stc_timing_ctrl.v */
// Two-lane two-wire bus timing, supervision and pin control with Wishbone registers
//
// Overview of operation
// - SDA hold of 3 clocks normally; with extension 11 setup and 12 hold.
// - Setup delay counts from the engine's new SDA value; same write means zero extra.
// - With SCL-low timeout on, timer reloads while SCL high, counts while low.
// - With free timeout on, bus is free after both lines high over 10 periods.
// - By default SDA sits on the lower pin and SCL on the next pin.
// - With the swap bit set, SCL takes the lower pin and SDA the next.
// - Default START needs SCL falling at least one clock after SDA fell.
// - The START delay field adds 2, 4 or 8 clocks to the required gap.
`timescale 1ns/10ps
`include "stc_defines.vh"
module stc_timing_ctrl (
  input wire mclk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire irq_o,
  input wire [1:0] pin_lo_i,
  output wire [1:0] pin_lo_o,
  output wire [1:0] pin_lo_oe_n_o,
  input wire [1:0] pin_hi_i,
  output wire [1:0] pin_hi_o,
  output wire [1:0] pin_hi_oe_n_o,
  input wire [1:0] sda_req_i,
  input wire [1:0] scl_req_i,
  input wire [1:0] bit_tick_i,
  input wire [1:0] timer_ovf_i,
  output wire [1:0] sda_o,
  output wire [1:0] scl_o,
  output wire [1:0] start_o,
  output wire [1:0] bus_free_o,
  output wire [1:0] timer_reload_o,
  output wire [1:0] timer_count_o
);
  reg [15:0] ctrl_reg;
  reg [15:0] ctrl_next;
  reg [5:0] status_reg;
  reg [5:0] status_next;
  reg [5:0] mask_reg;
  reg [5:0] mask_next;
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  wire [5:0] ev_set;
  wire [7:0] line_state;
  wire wb_req;
  wire wb_wr;

  // Wishbone classic slave, ack one cycle after request
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign irq_o = |(status_reg & mask_reg);

  always @* begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    if (wb_wr && wb_adr_i == `STC_OFS_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl_next[7:0] = {1'b0, wb_dat_i[6:0]};
      end
      if (wb_sel_i[1]) begin
        ctrl_next[15:8] = {1'b0, wb_dat_i[14:8]};
      end
    end
    if (wb_wr && wb_adr_i == `STC_OFS_MASK && wb_sel_i[0]) begin
      mask_next = wb_dat_i[5:0];
    end
    // Write one to clear; a new event in the same cycle wins
    if (wb_wr && wb_adr_i == `STC_OFS_STATUS && wb_sel_i[0]) begin
      status_next = status_reg & ~wb_dat_i[5:0];
    end
    status_next = status_next | ev_set;
  end

  always @* begin
    rdata_next = 32'h00000000;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `STC_OFS_CTRL: begin
          rdata_next = {16'h0000, ctrl_reg};
        end
        `STC_OFS_STATUS: begin
          rdata_next = {26'h0, status_reg};
        end
        `STC_OFS_MASK: begin
          rdata_next = {26'h0, mask_reg};
        end
        `STC_OFS_LINES: begin
          rdata_next = {24'h000000, line_state};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `STC_CTRL_RESET;
      status_reg <= 6'h00;
      mask_reg <= 6'h00;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      ack_reg <= wb_req;
      rdata_reg <= rdata_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `STC_NUM_LANES; g = g + 1) begin : lane
      // Own copy of every setting per lane
      wire [7:0] cf = ctrl_reg[g*`STC_LANE_W +: `STC_LANE_W];
      wire en = cf[`STC_F_EN];
      wire swap = cf[`STC_F_SWAP];
      wire ext = cf[`STC_F_EXT];
      wire lo_s;
      wire hi_s;
      wire sda_in;
      wire scl_in;
      wire sda_fall;
      wire sda_rise;
      wire scl_fall;
      wire hold_ok;
      wire setup_ok;
      reg [3:0] gap_need;
      reg sda_d_reg;
      reg scl_d_reg;
      reg armed_reg;
      reg armed_next;
      reg [3:0] gap_reg;
      reg [3:0] gap_next;
      reg start_reg;
      reg [3:0] free_cnt_reg;
      reg [3:0] free_cnt_next;
      reg free_reg;
      reg free_next;
      reg [3:0] low_cnt_reg;
      reg [3:0] set_cnt_reg;
      reg sda_drv_reg;
      reg sda_drv_next;
      reg scl_drv_reg;
      reg scl_drv_next;

      stc_sync u_sync_lo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .async_i(pin_lo_i[g]),
        .level_o(lo_s)
      );

      stc_sync u_sync_hi (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .async_i(pin_hi_i[g]),
        .level_o(hi_s)
      );

      // Lower pin is SDA by default, SCL when swapped
      assign sda_in = swap ? hi_s : lo_s;
      assign scl_in = swap ? lo_s : hi_s;
      assign sda_fall = sda_d_reg & ~sda_in;
      assign sda_rise = ~sda_d_reg & sda_in;
      assign scl_fall = scl_d_reg & ~scl_in;

      always @* begin
        case (cf[`STC_F_SDD +: 2])
          2'b00: begin
            gap_need = `STC_GAP_BASE;
          end
          2'b01: begin
            gap_need = `STC_GAP_BASE + `STC_GAP_ADD1;
          end
          2'b10: begin
            gap_need = `STC_GAP_BASE + `STC_GAP_ADD2;
          end
          default: begin
            gap_need = `STC_GAP_BASE + `STC_GAP_ADD3;
          end
        endcase
      end

      // Gap counts clocks since SDA fell with SCL still high
      always @* begin
        armed_next = armed_reg;
        gap_next = gap_reg;
        if (!en || scl_fall || sda_rise || !scl_in) begin
          armed_next = 1'b0;
          gap_next = 4'h0;
        end else if (sda_fall) begin
          armed_next = 1'b1;
          gap_next = 4'h1;
        end else if (armed_reg && gap_reg != `STC_CNT_MAX) begin
          gap_next = gap_reg + 4'h1;
        end
      end

      // Free after more than the set number of source periods high
      always @* begin
        free_cnt_next = free_cnt_reg;
        free_next = free_reg;
        if (!en || !cf[`STC_F_FTE] || !sda_in || !scl_in) begin
          free_cnt_next = 4'h0;
          free_next = 1'b0;
        end else if (bit_tick_i[g] && !free_reg) begin
          if (free_cnt_reg == `STC_FREE_PERIODS) begin
            free_next = 1'b1;
          end else begin
            free_cnt_next = free_cnt_reg + 4'h1;
          end
        end
      end

      // SDA may change while SCL is low only after the hold time
      assign hold_ok = low_cnt_reg >= (ext ? `STC_HOLD_EXT : `STC_HOLD_NORM);
      // SCL released only after the setup time since the last SDA change
      assign setup_ok = set_cnt_reg >= (ext ? `STC_SETUP_EXT : `STC_SETUP_NORM);

      always @* begin
        sda_drv_next = sda_drv_reg;
        if (!en) begin
          sda_drv_next = 1'b0;
        end else if (scl_in || hold_ok) begin
          sda_drv_next = ~sda_req_i[g];
        end
      end

      always @* begin
        scl_drv_next = scl_drv_reg;
        if (!en) begin
          scl_drv_next = 1'b0;
        end else if (!scl_req_i[g]) begin
          scl_drv_next = 1'b1;
        end else if (setup_ok) begin
          scl_drv_next = 1'b0;
        end
      end

      always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          sda_d_reg <= 1'b1;
          scl_d_reg <= 1'b1;
          armed_reg <= 1'b0;
          gap_reg <= 4'h0;
          start_reg <= 1'b0;
          free_cnt_reg <= 4'h0;
          free_reg <= 1'b0;
          low_cnt_reg <= 4'h0;
          set_cnt_reg <= 4'h0;
          sda_drv_reg <= 1'b0;
          scl_drv_reg <= 1'b0;
        end else begin
          sda_d_reg <= sda_in;
          scl_d_reg <= scl_in;
          armed_reg <= armed_next;
          gap_reg <= gap_next;
          start_reg <= en & scl_fall & armed_reg & (gap_reg >= gap_need);
          free_cnt_reg <= free_cnt_next;
          free_reg <= free_next;
          if (scl_in) begin
            low_cnt_reg <= 4'h0;
          end else if (low_cnt_reg != `STC_CNT_MAX) begin
            low_cnt_reg <= low_cnt_reg + 4'h1;
          end
          if (sda_drv_next != sda_drv_reg) begin
            set_cnt_reg <= 4'h0;
          end else if (set_cnt_reg != `STC_CNT_MAX) begin
            set_cnt_reg <= set_cnt_reg + 4'h1;
          end
          sda_drv_reg <= sda_drv_next;
          scl_drv_reg <= scl_drv_next;
        end
      end

      // Open drain: output low, enable low while pulling the line
      assign pin_lo_o[g] = 1'b0;
      assign pin_hi_o[g] = 1'b0;
      assign pin_lo_oe_n_o[g] = ~(swap ? scl_drv_reg : sda_drv_reg);
      assign pin_hi_oe_n_o[g] = ~(swap ? sda_drv_reg : scl_drv_reg);

      // Associated timer reloads on SCL high, counts on SCL low
      assign timer_reload_o[g] = en & cf[`STC_F_TOE] & scl_in;
      assign timer_count_o[g] = en & cf[`STC_F_TOE] & ~scl_in;

      assign sda_o[g] = sda_in;
      assign scl_o[g] = scl_in;
      assign start_o[g] = start_reg;
      assign bus_free_o[g] = free_reg;

      assign ev_set[g*`STC_EV_PER_LANE + `STC_EV_START] = start_reg;
      assign ev_set[g*`STC_EV_PER_LANE + `STC_EV_FREE] = free_next & ~free_reg;
      assign ev_set[g*`STC_EV_PER_LANE + `STC_EV_TMO] = timer_ovf_i[g] & en & cf[`STC_F_TOE];
      assign line_state[g*4 +: 4] = {armed_reg, free_reg, scl_in, sda_in};
    end
  endgenerate
endmodule // stc_timing_ctrl

/* File: test/stc_timing_ctrl_assertions.sv */
// Port-level checker of the two-wire timing block
`timescale 1ns/10ps
module stc_timing_ctrl_assertions (
  input wire mclk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [1:0] pin_lo_o,
  input wire [1:0] pin_hi_o,
  input wire [1:0] bit_tick_i,
  input wire [1:0] sda_o,
  input wire [1:0] scl_o,
  input wire [1:0] start_o,
  input wire [1:0] bus_free_o,
  input wire [1:0] timer_reload_o,
  input wire [1:0] timer_count_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  chk_start_gap: assert property (start_o[0] |-> $past(scl_o[0], 2) && !$past(scl_o[0])
    && !$past(sda_o[0], 2)) else $error("start without sda first");
  chk_free_lines_high: assert property (bus_free_o[0] |-> $past(sda_o[0]) && $past(scl_o[0]))
    else $error("free while a line low");
  chk_free_on_tick: assert property ($rose(bus_free_o[0]) |-> $past(bit_tick_i[0]))
    else $error("free set without tick");
  chk_reload_scl_high: assert property (timer_reload_o[0] |-> scl_o[0] && !timer_count_o[0])
    else $error("reload while scl low");
  chk_count_scl_low: assert property (timer_count_o[0] |-> !scl_o[0] && !timer_reload_o[0])
    else $error("count while scl high");
  chk_pins_open_drain: assert property (pin_lo_o == 2'h0 && pin_hi_o == 2'h0)
    else $error("pin driven high");
endmodule // stc_timing_ctrl_assertions
bind stc_timing_ctrl stc_timing_ctrl_assertions chk_u (.mclk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .pin_lo_o, .pin_hi_o, .bit_tick_i, .sda_o, .scl_o, .start_o, .bus_free_o, .timer_reload_o,
  .timer_count_o);

/* File: test/stc_bus_agent.sv */
// Other bus parties on both lanes: pull-ups, wired-AND and a framed link clock
`timescale 1ns/10ps
module stc_bus_agent (
  input wire [1:0] swap_i,
  input wire [1:0] sda_pull_i,
  input wire [1:0] scl_pull_i,
  input wire [1:0] run_i,
  input wire [1:0] lo_oe_n_i,
  input wire [1:0] hi_oe_n_i,
  output wire [1:0] lo_o,
  output wire [1:0] hi_o
);
  reg link_clk = 1'b1;
  wire [1:0] scl_low = scl_pull_i | (run_i & {2{~link_clk}});
  // Link clock stands high outside frames
  initial begin
    #7;
    forever #80 link_clk = (|run_i) ? ~link_clk : 1'b1;
  end
  // Released lines go to the pull-up level
  assign lo_o = lo_oe_n_i & ~((swap_i & scl_low) | (~swap_i & sda_pull_i));
  assign hi_o = hi_oe_n_i & ~((swap_i & sda_pull_i) | (~swap_i & scl_low));
endmodule // stc_bus_agent

/* File: test/tb.sv */
// Self-checking bench of the two-wire timing block
`timescale 1ns/10ps
`include "stc_defines.vh"
module tb;
  reg mclk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [7:0] wb_adr_i = 0;
  reg [3:0] wb_sel_i = 0;
  reg [31:0] wb_dat_i = 0, rd;
  reg [1:0] sda_req = 3, scl_req = 3, tick = 0, ovf = 0, swap = 0, sda_pull = 0, scl_pull = 0, run = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_o;
  wire [1:0] lo_i, hi_i, lo_oe, hi_oe, sda_o, scl_o, start_o, free_o, rel_o, cnt_o;
  integer mismatches = 0, comparisons = 0, c, g, n, m, seen;
  always #10 mclk_i = ~mclk_i;
  stc_timing_ctrl dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .pin_lo_i(lo_i), .pin_lo_o(), .pin_lo_oe_n_o(lo_oe), .pin_hi_i(hi_i),
    .pin_hi_o(), .pin_hi_oe_n_o(hi_oe), .sda_req_i(sda_req), .scl_req_i(scl_req), .bit_tick_i(tick),
    .timer_ovf_i(ovf), .sda_o(sda_o), .scl_o(scl_o), .start_o(start_o), .bus_free_o(free_o),
    .timer_reload_o(rel_o), .timer_count_o(cnt_o));
  stc_bus_agent agent_u (.swap_i(swap), .sda_pull_i(sda_pull), .scl_pull_i(scl_pull), .run_i(run),
    .lo_oe_n_i(lo_oe), .hi_oe_n_i(hi_oe), .lo_o(lo_i), .hi_o(hi_i));
  task end_of_test;
    begin
      if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge mclk_i);
  endtask
  // Bounded wait ran out
  task lim(input integer k, input integer b);
    if (k >= b) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, 4'hF};
      t = 0;
      @(posedge mclk_i);
      while (wb_ack_o !== 1'b1) begin
        t = t + 1;
        if (t > 50) begin
          mismatches = mismatches + 1;
          end_of_test;
        end
        @(posedge mclk_i);
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge mclk_i);
    end
  endtask
  task t_regs;
    begin
      wb(0, `STC_OFS_CTRL, 0); chk("ctrl rst", rd, `STC_CTRL_RESET);
      wb(1, `STC_OFS_CTRL, 32'hFFFFFFFF); wb(0, `STC_OFS_CTRL, 0); chk("ctrl rw", rd, 32'h7F7F);
      wb(1, `STC_OFS_CTRL, 0); wb(1, 8'h10, 32'hFF); wb(0, 8'h10, 0); chk("unmapped", rd, 0);
      wb(0, `STC_OFS_LINES, 0); chk("lines idle", rd, 32'h33);
    end
  endtask
  // Gap just under and at the threshold for every delay code
  task t_start;
    for (c = 0; c < 4; c = c + 1) for (g = 0; g < 2; g = g + 1) begin
      wb(1, `STC_OFS_CTRL, 32'h40 | c);
      n = (c == 0) ? 1 : (1 << c) + 1;
      sda_pull[0] <= 1;
      cyc(n - 1 + g);
      scl_pull[0] <= 1;
      seen = 0;
      repeat (12) begin
        @(posedge mclk_i);
        seen = seen | start_o[0];
      end
      chk("start", seen, g);
      scl_pull[0] <= 0; cyc(8); sda_pull[0] <= 0; cyc(8);
    end
  endtask
  task t_swap;
    begin
      wb(1, `STC_OFS_CTRL, 32'h4440); swap <= 2'h2; sda_pull[1] <= 1; cyc(8);
      chk("swap sda", {sda_o[1], scl_o[1], sda_o[0]}, 3'h3);
      sda_pull[1] <= 0; sda_req <= 2'h0; cyc(8);
      chk("drive pins", {hi_oe, lo_oe}, 4'h6);
      chk("sda fb", sda_o, 2'h0);
      sda_req <= 3; swap <= 0; cyc(8);
    end
  endtask
  // Hold from filtered SCL low, then setup before SCL release
  task t_hold;
    for (c = 0; c < 2; c = c + 1) begin
      wb(1, `STC_OFS_CTRL, c ? 32'h60 : 32'h40);
      scl_pull[0] <= 1; scl_req[0] <= 0; n = 0; m = 0;
      while (scl_o[0] !== 1'b0 && n < 20) begin @(posedge mclk_i); n = n + 1; end
      lim(n, 20);
      sda_req[0] <= 0; n = 0;
      while (lo_oe[0] !== 1'b0 && n < 30) begin @(posedge mclk_i); n = n + 1; end
      lim(n, 30);
      chk("hold", (n >= (c ? 8 : 0)) && (n <= (c ? 16 : 6)), 1);
      scl_req[0] <= 1;
      while (hi_oe[0] !== 1'b1 && m < 30) begin @(posedge mclk_i); m = m + 1; end
      lim(m, 30);
      chk("setup", (m >= (c ? 10 : 0)) && (m <= (c ? 19 : 9)), 1);
      scl_pull[0] <= 0; sda_req[0] <= 1; cyc(10);
    end
  endtask
  task t_free;
    begin
      wb(1, `STC_OFS_CTRL, 32'h50);
      repeat (10) begin tick[0] <= 1; cyc(1); tick[0] <= 0; cyc(2); end
      chk("free 10", free_o[0], 0);
      tick[0] <= 1; cyc(1); tick[0] <= 0; cyc(2);
      chk("free 11", free_o[0], 1);
      sda_pull[0] <= 1; cyc(7); chk("free off", free_o[0], 0);
      sda_pull[0] <= 0; cyc(6);
    end
  endtask
  task t_timer;
    begin
      wb(1, `STC_OFS_CTRL, 32'h48); wb(1, `STC_OFS_STATUS, 32'h3F); wb(1, `STC_OFS_MASK, 0);
      wb(0, `STC_OFS_STATUS, 0); chk("w1c", rd, 0);
      cyc(6); chk("reload", {rel_o[0], cnt_o[0]}, 2'h2);
      run <= 1; cyc(60); run <= 0; scl_pull[0] <= 1; cyc(8);
      chk("count", {rel_o[0], cnt_o[0]}, 2'h1);
      ovf[0] <= 1; cyc(1); ovf[0] <= 0; cyc(2);
      chk("masked", irq_o, 0);
      wb(0, `STC_OFS_STATUS, 0); chk("ovf bit", rd, 32'h4);
      wb(1, `STC_OFS_MASK, 32'h4); chk("irq", irq_o, 1);
      wb(1, `STC_OFS_STATUS, 32'h4); chk("irq clr", irq_o, 0);
      scl_pull[0] <= 0; cyc(6);
    end
  endtask
  initial begin
    cyc(10);
    rst_i <= 0;
    cyc(1);
    t_regs; t_start; t_swap; t_hold; t_free; t_timer;
    end_of_test;
  end
endmodule // tb
